// ---- alarm_event_pkg.sv ----
// constants and carrier types for the alarm event register
package alarm_event_pkg;

  localparam int NUM_EVENTS = 14;

  // event bit codes, bit index equals code
  localparam logic [3:0] EV_CPU_TEMP = 4'h0;
  localparam logic [3:0] EV_HIGH_FLOW = 4'h1;
  localparam logic [3:0] EV_LOW_FLOW = 4'h2;
  localparam logic [3:0] EV_IN_RANGE = 4'h3;
  localparam logic [3:0] EV_TOT1_LIMIT = 4'h4;
  localparam logic [3:0] EV_TOT2_LIMIT = 4'h5;
  localparam logic [3:0] EV_PULSE_OVF = 4'h6;
  localparam logic [3:0] EV_RATE_LIMIT = 4'h7;
  localparam logic [3:0] EV_SUPPLY = 4'h8;
  localparam logic [3:0] EV_SERIAL_ERR = 4'h9;
  localparam logic [3:0] EV_MEMORY_ERR = 4'hA;
  localparam logic [3:0] EV_POWER_ON = 4'hB;
  localparam logic [3:0] EV_PASSWORD = 4'hC;
  localparam logic [3:0] EV_FATAL = 4'hD;
  localparam logic [3:0] EV_LAST = EV_FATAL;

  // reset values and the zero power-up delay setting
  localparam logic [13:0] STATUS_RST = 14'h0000;
  localparam logic [13:0] LATCH_MASK_RST = 14'h0001;
  localparam logic [13:0] ENABLE_MASK_RST = 14'h0001;
  localparam logic [11:0] DELAY_NONE = 12'h000;

  // display holds this many event lines at once
  localparam logic [3:0] VISIBLE_LINES = 4'h7;

  typedef enum logic [1:0] {
    MENU_STATUS,
    MENU_LATCH,
    MENU_ENABLE,
    MENU_RESET
  } menu_t;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ_STATUS,
    CMD_READ_LATCH,
    CMD_READ_ENABLE,
    CMD_WRITE_LATCH,
    CMD_WRITE_ENABLE,
    CMD_CLEAR,
    CMD_READ_COUNT
  } ser_cmd_t;

  typedef enum logic {
    NVM_SEL_LATCH,
    NVM_SEL_ENABLE
  } nvm_sel_t;

  typedef struct packed {
    logic up;
    logic down;
    logic right;
    logic accept;
    logic yes;
  } keys_t;

  typedef struct packed {
    logic valid;
    ser_cmd_t cmd;
    logic [13:0] data;
  } ser_req_t;

  typedef struct packed {
    logic valid;
    logic [13:0] data;
  } ser_rsp_t;

  typedef struct packed {
    logic valid;
    nvm_sel_t sel;
    logic [13:0] data;
  } nvm_wr_t;

  typedef struct packed {
    logic valid;
    logic [13:0] latch;
    logic [13:0] enable;
  } nvm_load_t;

  typedef struct packed {
    logic [3:0] count;
    logic [3:0] top;
    logic [3:0] cursor;
    logic [13:0] edit;
    logic confirm;
  } disp_t;

  function automatic logic [3:0] count_ones(input logic [13:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NUM_EVENTS; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : count_ones

  function automatic logic [3:0] scroll_max(input logic [3:0] n);
    return (n > VISIBLE_LINES) ? n - VISIBLE_LINES : 4'h0;
  endfunction : scroll_max

endpackage : alarm_event_pkg

// ---- alarm_event_register.sv ----
// alarm event register: masks, keypad editing, serial access, display
`timescale 1ns/1ps
module alarm_event_register
  import alarm_event_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // event conditions, bit index is the event code
  input wire logic [13:0] EVENT_IN,
  // power-up delay setting in seconds
  input wire logic [11:0] POWER_UP_DELAY,
  // operator keypad and current menu screen
  input wire alarm_event_pkg::menu_t MENU,
  input wire alarm_event_pkg::keys_t KEYS,
  // stored masks returned from nonvolatile memory
  input wire alarm_event_pkg::nvm_load_t NVM_LOAD,
  // serial command port
  input wire alarm_event_pkg::ser_req_t SER_REQ,
  // status and answers
  output logic [13:0] EVENT_STATUS,
  output alarm_event_pkg::ser_rsp_t SER_RSP,
  output alarm_event_pkg::nvm_wr_t NVM_WR,
  output alarm_event_pkg::disp_t DISP
);

  import alarm_event_pkg::*;

  typedef struct packed {
    logic [13:0] latch_mask;
    logic [13:0] enable_mask;
    logic [13:0] edit_buf;
    logic [3:0] cursor;
    menu_t menu_prev;
    logic [3:0] top;
    logic [3:0] count;
    logic clr_pend;
    logic confirm;
    logic pon;
    logic loaded;
    nvm_wr_t nvm;
    ser_rsp_t rsp;
  } top_state_t;

  localparam top_state_t ST_RST = '{
    latch_mask: LATCH_MASK_RST,
    enable_mask: ENABLE_MASK_RST,
    edit_buf: LATCH_MASK_RST,
    cursor: 4'h0,
    menu_prev: MENU_STATUS,
    top: 4'h0,
    count: 4'h0,
    clr_pend: 1'b0,
    confirm: 1'b0,
    pon: 1'b1,
    loaded: 1'b0,
    nvm: '{valid: 1'b0, sel: NVM_SEL_LATCH, data: 14'h0000},
    rsp: '{valid: 1'b0, data: 14'h0000}
  };

  top_state_t st_q;
  top_state_t st_d;

  logic [13:0] cond_w;
  logic [13:0] status_w;
  logic clear_w;
  logic key_clear_w;
  logic ser_clear_w;
  logic ser_write_w;
  logic same_menu_w;
  logic [3:0] max_top_w;

  // power-on is generated here, so the outside line for that code is ignored
  always_comb begin
    cond_w = EVENT_IN;
    cond_w[EV_POWER_ON] = st_q.pon && (POWER_UP_DELAY != DELAY_NONE);
  end

  assign key_clear_w = (MENU == MENU_RESET) && (st_q.menu_prev == MENU_RESET) && KEYS.yes;
  assign ser_clear_w = SER_REQ.valid && (SER_REQ.cmd == CMD_CLEAR);
  assign clear_w = key_clear_w || ser_clear_w;
  assign ser_write_w = SER_REQ.valid
    && ((SER_REQ.cmd == CMD_WRITE_LATCH) || (SER_REQ.cmd == CMD_WRITE_ENABLE));
  assign same_menu_w = (MENU == st_q.menu_prev);
  assign max_top_w = scroll_max(st_q.count);

  event_status_reg u_status (
    .clk(REF_CLK),
    .rst(RST),
    .cond(cond_w),
    .enable(st_q.enable_mask),
    .latch(st_q.latch_mask),
    .clear(clear_w),
    .status(status_w)
  );

  always_comb begin
    st_d = st_q;
    // power-on stands until the stored masks have been in force for one cycle;
    // a one-cycle pulse would always meet the reset-default enable mask and be lost.
    // limitation: with no stored-mask load the power-on condition stays present
    st_d.pon = st_q.pon && !st_q.loaded;
    st_d.menu_prev = MENU;
    st_d.clr_pend = clear_w;
    // confirmation follows the cycle in which status reads empty
    st_d.confirm = st_q.clr_pend;
    st_d.count = count_ones(status_w);
    st_d.nvm.valid = 1'b0;
    st_d.rsp.valid = 1'b0;

    // stored masks arrive after power-up and replace the factory defaults
    if (NVM_LOAD.valid) begin
      st_d.latch_mask = NVM_LOAD.latch;
      st_d.enable_mask = NVM_LOAD.enable;
      st_d.loaded = 1'b1;
    end

    if (!same_menu_w) begin
      // entering a screen starts a fresh edit copy and an unscrolled list
      st_d.cursor = 4'h0;
      st_d.top = 4'h0;
      st_d.edit_buf = (MENU == MENU_LATCH) ? st_q.latch_mask : st_q.enable_mask;
    end else begin
      unique case (MENU)
        MENU_STATUS: begin
          // the list can shrink under the operator, so pull the top back first
          if (st_q.top > max_top_w) begin
            st_d.top = max_top_w;
          end else if (KEYS.down && (st_q.top < max_top_w)) begin
            st_d.top = st_q.top + 4'h1;
          end else if (KEYS.up && (st_q.top != 4'h0)) begin
            st_d.top = st_q.top - 4'h1;
          end
        end
        MENU_LATCH, MENU_ENABLE: begin
          if (KEYS.accept) begin
            st_d.nvm.valid = 1'b1;
            st_d.nvm.data = st_q.edit_buf;
            if (MENU == MENU_LATCH) begin
              st_d.latch_mask = st_q.edit_buf;
              st_d.nvm.sel = NVM_SEL_LATCH;
            end else begin
              st_d.enable_mask = st_q.edit_buf;
              st_d.nvm.sel = NVM_SEL_ENABLE;
            end
          end else if (KEYS.right) begin
            st_d.edit_buf[st_q.cursor] = ~st_q.edit_buf[st_q.cursor];
          end else if (KEYS.up && (st_q.cursor != 4'h0)) begin
            st_d.cursor = st_q.cursor - 4'h1;
          end else if (KEYS.down && (st_q.cursor < EV_LAST)) begin
            st_d.cursor = st_q.cursor + 4'h1;
          end
        end
        MENU_RESET: begin
          st_d.top = 4'h0;
        end
      endcase
    end

    // serial writes come last so they win over a keypad accept in the same cycle
    if (SER_REQ.valid) begin
      st_d.rsp.valid = 1'b1;
      st_d.rsp.data = 14'h0000;
      unique case (SER_REQ.cmd)
        CMD_READ_STATUS: begin
          st_d.rsp.data = status_w;
        end
        CMD_READ_LATCH: begin
          st_d.rsp.data = st_q.latch_mask;
        end
        CMD_READ_ENABLE: begin
          st_d.rsp.data = st_q.enable_mask;
        end
        CMD_READ_COUNT: begin
          st_d.rsp.data = {10'h000, count_ones(status_w)};
        end
        CMD_WRITE_LATCH: begin
          st_d.latch_mask = SER_REQ.data;
          st_d.nvm.valid = 1'b1;
          st_d.nvm.sel = NVM_SEL_LATCH;
          st_d.nvm.data = SER_REQ.data;
        end
        CMD_WRITE_ENABLE: begin
          st_d.enable_mask = SER_REQ.data;
          st_d.nvm.valid = 1'b1;
          st_d.nvm.sel = NVM_SEL_ENABLE;
          st_d.nvm.data = SER_REQ.data;
        end
        CMD_CLEAR, CMD_NONE: begin
          st_d.rsp.data = 14'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign EVENT_STATUS = status_w;
  assign SER_RSP = st_q.rsp;
  assign NVM_WR = st_q.nvm;
  assign DISP = '{
    count: st_q.count,
    top: st_q.top,
    cursor: st_q.cursor,
    edit: st_q.edit_buf,
    confirm: st_q.confirm
  };

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_reset_masks: assert property ($past(RST) |->
    st_q.latch_mask == LATCH_MASK_RST && st_q.enable_mask == ENABLE_MASK_RST)
    else $error("masks not at factory defaults after reset");

  a_pon_blocked: assert property (st_q.pon && POWER_UP_DELAY == DELAY_NONE
    |=> !EVENT_STATUS[EV_POWER_ON])
    else $error("power-on event raised with zero delay");

  a_pon_raised: assert property (st_q.pon && POWER_UP_DELAY != DELAY_NONE
    && st_q.enable_mask[EV_POWER_ON] && !clear_w |=> EVENT_STATUS[EV_POWER_ON])
    else $error("power-on event missing");

  a_pon_ends: assert property (st_q.loaded |=> !st_q.pon)
    else $error("power-on condition outlives the mask load");

  a_clear_confirm: assert property (clear_w |=> EVENT_STATUS == STATUS_RST
    ##1 DISP.confirm)
    else $error("clear not followed by empty status and confirmation");

  a_enable_gate: assert property ((cond_w & ~st_q.enable_mask) != 14'h0000
    && (EVENT_STATUS & cond_w & ~st_q.enable_mask) == 14'h0000
    |=> (EVENT_STATUS & $past(cond_w & ~st_q.enable_mask)) == 14'h0000)
    else $error("disabled event recorded");

  a_latch_store: assert property (MENU == MENU_LATCH && same_menu_w && KEYS.accept
    && !ser_write_w |=> NVM_WR.valid && NVM_WR.sel == NVM_SEL_LATCH
    && NVM_WR.data == $past(st_q.edit_buf) && st_q.latch_mask == $past(st_q.edit_buf))
    else $error("latch mask accept not stored");

  a_enable_store: assert property (MENU == MENU_ENABLE && same_menu_w && KEYS.accept
    && !ser_write_w |=> NVM_WR.valid && NVM_WR.sel == NVM_SEL_ENABLE
    && st_q.enable_mask == $past(st_q.edit_buf))
    else $error("enable mask accept not stored");

  a_serial_read: assert property (SER_REQ.valid && SER_REQ.cmd == CMD_READ_STATUS
    |=> SER_RSP.valid && SER_RSP.data == $past(status_w))
    else $error("serial status read wrong");

  a_serial_answer: assert property (SER_REQ.valid |=> SER_RSP.valid)
    else $error("serial command not answered");

  a_serial_write: assert property (ser_write_w |=> NVM_WR.valid
    && NVM_WR.data == $past(SER_REQ.data))
    else $error("serial mask write not stored");

  a_load_masks: assert property (NVM_LOAD.valid && !ser_write_w && !KEYS.accept |=>
    st_q.latch_mask == $past(NVM_LOAD.latch)
    && st_q.enable_mask == $past(NVM_LOAD.enable))
    else $error("stored masks not taken over");

  a_header_count: assert property (1'b1 |=> DISP.count == count_ones($past(status_w)))
    else $error("active event count wrong");

  a_scroll_limit: assert property (st_q.count <= VISIBLE_LINES |=> DISP.top == 4'h0)
    else $error("list scrolled with seven or fewer events");

  c_key_clear: cover property (key_clear_w ##2 DISP.confirm);
  c_latch_accept: cover property (MENU == MENU_LATCH && same_menu_w && KEYS.accept);
  c_scrolled: cover property (DISP.top != 4'h0);
  c_power_on: cover property (EVENT_STATUS[EV_POWER_ON]);

endmodule : alarm_event_register

// ---- alarm_event_register_tb.sv ----
// self-checking testbench for the alarm event register
`timescale 1ns/1ps
module alarm_event_register_tb;
  import alarm_event_pkg::*;
  typedef struct packed {
    logic [13:0] en;
    logic [13:0] lat;
    logic [13:0] ev;
    logic [13:0] set_v;
    logic [13:0] hold_v;
  } row_t;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [13:0] ev_in = 14'h0000;
  // zero delay for the main run; the second reset sets it nonzero
  logic [11:0] pud = 12'h000;
  menu_t menu = MENU_STATUS;
  keys_t keys = '0;
  nvm_load_t nvm_ld = '0;
  ser_req_t ser_req;
  logic [13:0] status;
  ser_rsp_t ser_rsp;
  nvm_wr_t nvm_wr;
  disp_t disp;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [13:0] q;
  logic ok;
  // enable, latch, event, status while present, status after it ends
  row_t rows [4] = '{
    '{14'h3FFF, 14'h0000, 14'h00FF, 14'h00FF, 14'h0000},
    '{14'h3FFF, 14'h3FFF, 14'h3F00, 14'h3700, 14'h3700},
    '{14'h0000, 14'h3FFF, 14'h3FFF, 14'h0000, 14'h0000},
    '{14'h0055, 14'h000F, 14'h00FF, 14'h0055, 14'h0005}
  };

  always #10 ref_clk = ~ref_clk;

  alarm_event_register dut_u (
    .REF_CLK(ref_clk),
    .RST(rst),
    .EVENT_IN(ev_in),
    .POWER_UP_DELAY(pud),
    .MENU(menu),
    .KEYS(keys),
    .NVM_LOAD(nvm_ld),
    .SER_REQ(ser_req),
    .EVENT_STATUS(status),
    .SER_RSP(ser_rsp),
    .NVM_WR(nvm_wr),
    .DISP(disp)
  );

  alarm_host_model host_u (
    .clk(ref_clk),
    .req(ser_req),
    .rsp(ser_rsp)
  );

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // the whole run needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk_val(input string name, input logic [13:0] exp, input logic [13:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  function automatic logic [13:0] ones(input logic [13:0] v);
    ones = 14'h0000;
    for (int i = 0; i < 14; i++) begin
      ones = ones + {13'h0000, v[i]};
    end
  endfunction : ones

  task automatic rd(input ser_cmd_t cmd, input logic [13:0] exp, input string name);
    host_u.xfer(cmd, 14'h0000, q, ok);
    chk_bit("serial answer", 1'h1, ok);
    chk_val(name, exp, q);
  endtask : rd

  task automatic wr(input ser_cmd_t cmd, input logic [13:0] d);
    host_u.xfer(cmd, d, q, ok);
    chk_bit("serial answer", 1'h1, ok);
    chk_val("write answer", 14'h0000, q);
  endtask : wr

  // enter an edit screen, one key, toggle, accept, then look at the store
  task automatic edit(input menu_t m, input logic [4:0] k, input nvm_sel_t s,
                      input logic [13:0] exp);
    @(posedge ref_clk);
    menu <= m;
    @(posedge ref_clk);
    keys <= k;
    @(posedge ref_clk);
    keys <= 5'h04;
    @(posedge ref_clk);
    keys <= 5'h02;
    @(posedge ref_clk);
    keys <= 5'h00;
    #1;
    chk_bit("store valid", 1'h1, nvm_wr.valid);
    chk_bit("store select", s, nvm_wr.sel);
    chk_val("store data", exp, nvm_wr.data);
    chk_val("edit copy", exp, disp.edit);
    chk_val("edit cursor", {13'h0000, k[3]}, {10'h000, disp.cursor});
  endtask : edit

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk_val("status after reset", 14'h0000, status);
    @(posedge ref_clk);
    #1;
    chk_val("power-on with zero delay", 14'h0000, status);
    rd(CMD_READ_LATCH, 14'h0001, "default latch");
    rd(CMD_READ_ENABLE, 14'h0001, "default enable");
    foreach (rows[i]) begin
      wr(CMD_WRITE_ENABLE, rows[i].en);
      wr(CMD_WRITE_LATCH, rows[i].lat);
      wr(CMD_CLEAR, 14'h0000);
      @(posedge ref_clk);
      ev_in <= rows[i].ev;
      @(posedge ref_clk);
      ev_in <= 14'h0000;
      #1;
      chk_val("status set", rows[i].set_v, status);
      @(posedge ref_clk);
      #1;
      chk_val("status after", rows[i].hold_v, status);
      @(posedge ref_clk);
      #1;
      chk_val("count", ones(rows[i].hold_v), {10'h000, disp.count});
      rd(CMD_READ_STATUS, rows[i].hold_v, "serial status");
      rd(CMD_READ_COUNT, ones(rows[i].hold_v), "serial count");
    end
    // yes on the entry cycle is ignored, a later yes clears and beats a set
    @(posedge ref_clk);
    menu <= MENU_RESET;
    keys <= 5'h01;
    @(posedge ref_clk);
    keys <= 5'h00;
    #1;
    chk_val("yes on entry", 14'h0005, status);
    @(posedge ref_clk);
    keys <= 5'h01;
    ev_in <= 14'h0001;
    @(posedge ref_clk);
    keys <= 5'h00;
    ev_in <= 14'h0000;
    #1;
    chk_val("clear beats set", 14'h0000, status);
    chk_bit("confirm early", 1'h0, disp.confirm);
    @(posedge ref_clk);
    #1;
    chk_bit("confirm", 1'h1, disp.confirm);
    edit(MENU_LATCH, 5'h08, NVM_SEL_LATCH, 14'h000D);
    rd(CMD_READ_LATCH, 14'h000D, "edited latch");
    edit(MENU_ENABLE, 5'h10, NVM_SEL_ENABLE, 14'h0054);
    rd(CMD_READ_ENABLE, 14'h0054, "edited enable");
    // nine latched events: the list scrolls by at most two lines
    wr(CMD_WRITE_ENABLE, 14'h3FFF);
    wr(CMD_WRITE_LATCH, 14'h3FFF);
    @(posedge ref_clk);
    menu <= MENU_STATUS;
    ev_in <= 14'h01FF;
    @(posedge ref_clk);
    ev_in <= 14'h0000;
    @(posedge ref_clk);
    repeat (3) begin
      @(posedge ref_clk);
      keys <= 5'h08;
      @(posedge ref_clk);
      keys <= 5'h00;
    end
    #1;
    chk_val("count of nine", 14'h0009, {10'h000, disp.count});
    chk_val("scroll end", 14'h0002, {10'h000, disp.top});
    @(posedge ref_clk);
    keys <= 5'h10;
    @(posedge ref_clk);
    keys <= 5'h00;
    #1;
    chk_val("scroll up", 14'h0001, {10'h000, disp.top});
    @(posedge ref_clk);
    nvm_ld <= '{valid: 1'h1, latch: 14'h0123, enable: 14'h0456};
    @(posedge ref_clk);
    nvm_ld <= '0;
    rd(CMD_READ_LATCH, 14'h0123, "loaded latch");
    rd(CMD_READ_ENABLE, 14'h0456, "loaded enable");
    // second reset with a nonzero delay: the loaded mask lets power-on through
    @(posedge ref_clk);
    rst <= 1'h1;
    pud <= 12'h001;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    nvm_ld <= '{valid: 1'h1, latch: 14'h0800, enable: 14'h0801};
    @(posedge ref_clk);
    nvm_ld <= '0;
    #1;
    chk_val("status after second reset", 14'h0000, status);
    @(posedge ref_clk);
    #1;
    chk_val("power-on event", 14'h0800, status);
    @(posedge ref_clk);
    #1;
    chk_val("power-on latched", 14'h0800, status);
    give_verdict();
  end
endmodule : alarm_event_register_tb

// ---- alarm_host_model.sv ----
// host model: serial command master facing the alarm event register
`timescale 1ns/1ps
module alarm_host_model
  import alarm_event_pkg::*;
(
  // clock
  input wire logic clk,
  // serial command port
  output alarm_event_pkg::ser_req_t req,
  input wire alarm_event_pkg::ser_rsp_t rsp
);
  import alarm_event_pkg::*;
  initial req = '0;
  // one-cycle command; the answer is taken in the cycle after it
  task automatic xfer(input ser_cmd_t cmd, input logic [13:0] d, output logic [13:0] q,
                      output logic ok);
    @(posedge clk);
    req <= '{valid: 1'h1, cmd: cmd, data: d};
    @(posedge clk);
    // released data is inverted so a stale value can never pass as fresh
    req <= '{valid: 1'h0, cmd: CMD_NONE, data: ~d};
    #1;
    ok = rsp.valid;
    q = rsp.data;
  endtask : xfer
endmodule : alarm_host_model

// ---- event_status_reg.sv ----
// volatile event status bits with latch and enable masking
`timescale 1ns/1ps
module event_status_reg
  import alarm_event_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // event conditions and masks
  input wire logic [13:0] cond,
  input wire logic [13:0] enable,
  input wire logic [13:0] latch,
  input wire logic clear,
  // reported status
  output logic [13:0] status
);

  typedef struct packed {
    logic [13:0] status;
  } status_state_t;

  status_state_t st_q;
  status_state_t st_d;

  always_comb begin
    st_d = st_q;
    // latched bits hold, live bits follow enabled conditions
    st_d.status = (st_q.status & latch) | (cond & enable);
    // clear wins over a same-cycle set
    if (clear) begin
      st_d.status = STATUS_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q.status <= STATUS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_status_cause: assert property (!$past(rst) |-> (status & ~($past(status & latch)
    | $past(cond & enable))) == 14'h0000)
    else $error("status bit set without enabled cause");
  a_clear_wins: assert property (clear |=> status == STATUS_RST)
    else $error("status not empty after clear");
  a_latch_hold: assert property (!clear ##0 (status & latch) != 14'h0000 |=>
    (status & $past(status & latch)) == $past(status & latch))
    else $error("latched event dropped without clear");
  a_live_follow: assert property (!clear |=>
    (status & ~$past(latch)) == ($past(cond & enable) & ~$past(latch)))
    else $error("unlatched event does not follow condition");
  a_volatile_reset: assert property ($past(rst) |-> status == STATUS_RST)
    else $error("status not cleared by reset");

endmodule : event_status_reg
